// [design/sep_params.svh]
// constants of the serial eeprom command and protection front end
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH
`define SEP_OP_WEN 8'h06
`define SEP_OP_WDI 8'h04
`define SEP_OP_RSR 8'h05
`define SEP_OP_WSR 8'h01
`define SEP_OP_RD 8'h03
`define SEP_OP_WR 8'h02
`define SEP_SR_ZERO 5
`define SEP_SR_WMASK 8'hDC
`define SEP_PAGE 64
`define SEP_BP_RST 2'b00
`define SEP_HPE_RST 1'b0
`define SEP_LOCK_RST 1'b0
`define SEP_SYS_MHZ 20
`define SEP_TWC_US 5000
`define SEP_TWC_CYC (`SEP_TWC_US * `SEP_SYS_MHZ)
`endif

// [design/sep_pkg.sv]
// types of the serial eeprom command and protection front end
package sep_pkg;
	typedef enum logic [1:0] {PH_OP, PH_ADDR, PH_BODY, PH_DEAD} sep_phase_t;
	typedef enum logic [1:0] {WK_NONE, WK_MEM, WK_ID, WK_SR} sep_wkind_t;
	typedef struct packed {
		logic [7:0]  sh;
		logic [2:0]  bitn;
		sep_phase_t  ph;
		logic        ab;
		logic [7:0]  op;
		logic [15:0] addr;
		logic [7:0]  srb;
		logic        sr_ok;
		logic        extra;
		logic [63:0] mask;
		logic [5:0]  wp;
		logic [7:0]  tx;
		logic [2:0]  txi;
		logic        tx_on;
		logic [7:0]  st1;
		logic [7:0]  st2;
	} sep_link_t;
	typedef struct packed {
		logic [2:0]  cs_s;
		logic [1:0]  wp_s;
		logic        wip;
		logic        wlat;
		logic        hpe;
		logic        ips;
		logic        lock;
		logic [1:0]  bp;
		sep_wkind_t  wk;
		logic [16:0] cnt;
		logic [6:0]  idx;
		logic [13:0] pa;
		logic [7:0]  srn;
	} sep_sys_t;
endpackage

// [design/sep_eeprom.sv]
// serial eeprom command decoder, status register and write protection
// Functional notes
// - modes 0 and 3, 8-bit instruction register
// - act only on six opcodes, ignore others
// - 06 enables writes, 04 disables writes
// - 05 reads status, 01 writes status
// - 03 reads memory, 02 writes memory
// - status layout: hpe, ips, 0, lock, bp, latch, wip
// - busy bit high during write, read only
// - enable sets latch, disable clears latch
// - block protect: none, quarter, half, all
// - wp low and hpe block status writes
// - protect matrix for array and status writes
// - id select steers access, clears after use
// - id lock makes page permanently read only
// - select and lock together: both unchanged
// - power up with latch cleared
// - latch set only if frame ends after opcode
// - 16-bit address, low 14 bits used
// - programming starts at frame end, busy ignores
// - 64-byte page, in-page address wraps
// - latch cleared when write cycle ends
// - id page uses a5..a0, protect range applies
// - full protection also refuses id writes
// - sample on rising, drive on falling clock
// - output off while deselected
`timescale 1ns/1ps
`include "sep_params.svh"
module sep_eeprom #(
	parameter logic [16:0] WRITE_CYCLES = 17'(`SEP_TWC_CYC)
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic spi_clk,
	input  wire logic select_n,
	input  wire logic spi_din,
	input  wire logic write_protect_n,
	output logic      spi_dout,
	output logic      spi_dout_oe
);
	import sep_pkg::*;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] mem_arr [16384];
	logic [7:0] id_arr [`SEP_PAGE];
	logic [7:0] pbuf [`SEP_PAGE];

	sep_link_t lr;
	sep_link_t ln;
	sep_sys_t  sr;
	sep_sys_t  sn;
	logic      live;
	logic      pb_we;
	logic [7:0] stat;
	logic      cs_rise;
	logic      hw_prot;
	logic      prog_we;

	function automatic logic [7:0] rd_byte(input logic ids, input logic [15:0] a);
		rd_byte = ids ? id_arr[a[5:0]] : mem_arr[a[13:0]];
	endfunction

	function automatic logic blk_prot(input logic [1:0] bp, input logic [13:0] a);
		unique case (bp)
			2'b00: blk_prot = 1'b0;
			2'b01: blk_prot = (a[13:12] == 2'b11);
			2'b10: blk_prot = a[13];
			2'b11: blk_prot = 1'b1;
		endcase
	endfunction

	assign stat = {sr.hpe, sr.ips, 1'b0, sr.lock, sr.bp, sr.wlat, sr.wip};

	// ----------------------------------------
	// link side, serial clock domain
	// ----------------------------------------
	// frame marker; cleared by the frame's own deselect, no clock needed
	always_ff @(posedge spi_clk, posedge select_n, negedge rst_n)
	begin
		if (!rst_n || select_n)
			live <= 1'b0;
		else
			live <= 1'b1;
	end

	always_comb
	begin
		sep_link_t c;
		logic [7:0] shn;
		logic       done;
		logic       busy;
		logic [15:0] na;
		c = lr;
		if (!live)
		begin
			c.bitn = 3'd0;
			c.ph = PH_OP;
			c.ab = 1'b0;
			c.extra = 1'b0;
			c.sr_ok = 1'b0;
			// stale opcode must not replay at the next frame end
			c.op = 8'h00;
			c.tx_on = 1'b0;
		end
		shn = {c.sh[6:0], spi_din};
		done = (c.bitn == 3'd7);
		busy = c.st2[0];
		na = {c.addr[14:0], spi_din};
		ln = c;
		ln.sh = shn;
		ln.bitn = c.bitn + 3'd1;
		ln.st1 = stat;
		ln.st2 = c.st1;
		pb_we = 1'b0;
		unique case (c.ph)
			PH_OP:
			begin
				if (done)
				begin
					ln.op = shn;
					ln.ph = PH_DEAD;
					// only status reads get through a running write cycle
					if (busy && shn != `SEP_OP_RSR)
						ln.op = 8'h00;
					else if (shn == `SEP_OP_RSR)
					begin
						ln.ph = PH_BODY;
						ln.tx = c.st2;
						ln.txi = 3'd7;
						ln.tx_on = 1'b1;
					end
					else if (shn == `SEP_OP_WSR)
						ln.ph = PH_BODY;
					else if (shn == `SEP_OP_RD || shn == `SEP_OP_WR)
					begin
						ln.ph = PH_ADDR;
						// cleared here, not at select, so busy polls keep it for programming
						ln.mask = '0;
					end
					else if (shn != `SEP_OP_WEN && shn != `SEP_OP_WDI)
						ln.op = 8'h00;
				end
			end
			PH_ADDR:
			begin
				ln.addr = na;
				if (done)
				begin
					ln.ab = 1'b1;
					if (c.ab)
					begin
						ln.ph = PH_BODY;
						ln.wp = na[5:0];
						if (c.op == `SEP_OP_RD)
						begin
							ln.tx = rd_byte(c.st2[6], na);
							ln.txi = 3'd7;
							ln.tx_on = 1'b1;
						end
					end
				end
			end
			PH_BODY:
			begin
				if (c.tx_on)
				begin
					ln.txi = c.txi - 3'd1;
					if (c.txi == 3'd0)
					begin
						if (c.op == `SEP_OP_RSR)
							ln.tx = c.st2;
						else
						begin
							// id page walks a5..a0 only
							ln.addr = c.st2[6] ? {c.addr[15:6], c.addr[5:0] + 6'd1}
								: {c.addr[15:14], c.addr[13:0] + 14'd1};
							ln.tx = rd_byte(c.st2[6], ln.addr);
						end
					end
				end
				else if (done && c.op == `SEP_OP_WR)
				begin
					pb_we = 1'b1;
					ln.mask[c.wp] = 1'b1;
					ln.wp = c.wp + 6'd1;
				end
				else if (done && !c.sr_ok)
				begin
					ln.srb = shn;
					ln.sr_ok = 1'b1;
				end
			end
			PH_DEAD:
				ln.extra = 1'b1;
		endcase
	end

	always_ff @(posedge spi_clk, negedge rst_n)
	begin
		if (!rst_n)
			lr <= '0;
		else
			lr <= ln;
	end

	// page buffer; refilled only while idle, so programming reads it stable
	always_ff @(posedge spi_clk)
	begin
		if (pb_we)
			pbuf[lr.wp] <= ln.sh;
	end

	always_ff @(negedge spi_clk, posedge select_n, negedge rst_n)
	begin
		if (!rst_n || select_n)
		begin
			spi_dout <= 1'b0;
			spi_dout_oe <= 1'b0;
		end
		else
		begin
			spi_dout <= lr.tx[lr.txi];
			// mode 3 falls before the first rise: gate the stale enable
			spi_dout_oe <= lr.tx_on & live;
		end
	end

	// ----------------------------------------
	// system side, write cycle and status
	// ----------------------------------------
	// link fields are read after deselect is synchronised, except the mask, read during programming while busy polls may clock
	assign cs_rise = sr.cs_s[1] & ~sr.cs_s[2];
	assign hw_prot = sr.hpe & ~sr.wp_s[1];
	assign prog_we = sr.wip && !sr.idx[6] && lr.mask[sr.idx[5:0]];

	always_comb
	begin
		logic ok;
		ok = 1'b0;
		sn = sr;
		sn.cs_s = {sr.cs_s[1:0], select_n};
		sn.wp_s = {sr.wp_s[0], write_protect_n};
		if (sr.wip)
		begin
			if (!sr.idx[6])
				sn.idx = sr.idx + 7'd1;
			sn.cnt = sr.cnt - 17'd1;
			if (sr.cnt == 17'd1)
			begin
				sn.wip = 1'b0;
				sn.wlat = 1'b0;
				if (sr.wk == WK_ID)
					sn.ips = 1'b0;
				if (sr.wk == WK_SR)
				begin
					sn.hpe = sr.srn[7];
					sn.bp = sr.srn[3:2];
					// a lock once set never clears
					if (!(sr.srn[6] && sr.srn[4]))
					begin
						sn.ips = sr.srn[6];
						sn.lock = sr.lock | sr.srn[4];
					end
				end
			end
		end
		else if (cs_rise)
		begin
			unique case (lr.op)
				`SEP_OP_WEN:
					if (!lr.extra)
						sn.wlat = 1'b1;
				`SEP_OP_WDI:
					if (!lr.extra)
						sn.wlat = 1'b0;
				`SEP_OP_WSR:
				begin
					ok = lr.sr_ok && sr.wlat && !hw_prot;
					sn.wk = WK_SR;
				end
				`SEP_OP_WR:
				begin
					if (sr.ips)
					begin
						ok = !sr.lock && sr.bp != 2'b11 && !blk_prot(sr.bp, lr.addr[13:0]);
						sn.wk = WK_ID;
					end
					else
					begin
						ok = !blk_prot(sr.bp, lr.addr[13:0]);
						sn.wk = WK_MEM;
					end
					ok = ok && sr.wlat && (lr.mask != '0);
				end
				`SEP_OP_RD:
					sn.ips = 1'b0;
				default:
					ok = 1'b0;
			endcase
			if (ok)
			begin
				sn.wip = 1'b1;
				sn.cnt = WRITE_CYCLES;
				sn.idx = 7'd0;
				sn.pa = lr.addr[13:0];
				sn.srn = lr.srb & `SEP_SR_WMASK;
			end
			else
				sn.wk = sr.wk;
		end
	end

	always_ff @(posedge sys_clk, negedge rst_n)
	begin
		if (!rst_n)
		begin
			sr <= '0;
			sr.cs_s <= 3'b111;
			sr.wp_s <= 2'b11;
			sr.bp <= `SEP_BP_RST;
			sr.hpe <= `SEP_HPE_RST;
			sr.lock <= `SEP_LOCK_RST;
		end
		else
			sr <= sn;
	end

	// one buffered byte per cycle over the first 64 cycles of the cycle timer
	always_ff @(posedge sys_clk)
	begin
		if (prog_we && sr.wk == WK_MEM)
			mem_arr[{sr.pa[13:6], sr.idx[5:0]}] <= pbuf[sr.idx[5:0]];
		if (prog_we && sr.wk == WK_ID)
			id_arr[sr.idx[5:0]] <= pbuf[sr.idx[5:0]];
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_frame_end;
		cs_rise && !sr.wip;
	endsequence

	write_enable_cmd_frame_a: assert property (
		seq_frame_end ##0 (lr.op == `SEP_OP_WEN && !lr.extra) |=> sr.wlat)
		else $error("enable frame did not set latch");
	latch_rise_a: assert property ($rose(sr.wlat) |-> $past(cs_rise))
		else $error("latch set without frame end");
	busy_len_a: assert property ($fell(sr.wip) |-> $past(sr.cnt) == 17'd1)
		else $error("write cycle ended early");
	latch_end_a: assert property ($fell(sr.wip) |-> !sr.wlat)
		else $error("latch kept after write cycle");
	sr_zero_a: assert property (stat[`SEP_SR_ZERO] == 1'b0)
		else $error("status bit 5 not zero");
	hw_prot_a: assert property (
		seq_frame_end ##0 (lr.op == `SEP_OP_WSR && hw_prot) |=> !sr.wip)
		else $error("protected status write started");
	id_full_a: assert property (
		seq_frame_end ##0 (lr.op == `SEP_OP_WR && sr.ips && sr.bp == 2'b11) |=> !sr.wip)
		else $error("id write under full protect");
	lock_keep_a: assert property (sr.lock |=> sr.lock)
		else $error("id lock cleared");
	both_bits_a: assert property (
		($fell(sr.wip) && sr.wk == WK_SR && sr.srn[6] && sr.srn[4])
		|-> sr.ips == $past(sr.ips) && sr.lock == $past(sr.lock))
		else $error("select and lock changed together");
	busy_ign_a: assert property (
		(sr.wip && sr.cnt > 17'd1 && cs_rise) |=> sr.wlat == $past(sr.wlat))
		else $error("command acted during busy");
endmodule

// [tb/sep_host.sv]
// serial host model for the eeprom link
`timescale 1ns/1ps
module sep_host (
	output logic      spi_clk,
	output logic      select_n,
	output logic      spi_din,
	input  wire logic spi_dout
);
	initial
	begin
		spi_clk = 1'b0;
		select_n = 1'b1;
		spi_din = 1'b0;
	end
	// clock only runs inside a frame, idles at the mode's level
	task automatic xfer(input int nb, input logic [31:0] tx, input logic cpol,
		output logic [7:0] rx);
		spi_clk = cpol;
		#6 select_n = 1'b0;
		for (int i = 8 * nb - 1; i >= 0; i--)
		begin
			#6 spi_clk = 1'b0;
			spi_din = tx[i];
			#6 spi_clk = 1'b1;
			rx = {rx[6:0], spi_dout};
		end
		#6 spi_clk = cpol;
		#6 select_n = 1'b1;
		// released line: inverse, not the last value
		spi_din = ~spi_din;
		#300;
	endtask
endmodule

// [tb/spi_eeprom_command_protect_tb.sv]
// self-checking bench of the eeprom command front end
`timescale 1ns/1ps
module spi_eeprom_command_protect_tb;
	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       write_protect_n = 1'b1;
	logic       spi_clk;
	logic       select_n;
	logic       spi_din;
	logic       spi_dout;
	logic       spi_dout_oe;
	logic [7:0] rx;
	logic       mode3 = 1'b0;
	int         oe_hits = 0;
	int         bad_count = 0;
	int         checks_done = 0;
	int         cycles = 0;
	always #25 sys_clk = ~sys_clk;
	// short write cycle keeps the run brief
	sep_eeprom #(.WRITE_CYCLES(17'h0_0064)) dut_u (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.spi_clk(spi_clk),
		.select_n(select_n),
		.spi_din(spi_din),
		.write_protect_n(write_protect_n),
		.spi_dout(spi_dout),
		.spi_dout_oe(spi_dout_oe)
	);
	sep_host host_u (
		.spi_clk(spi_clk),
		.select_n(select_n),
		.spi_din(spi_din),
		.spi_dout(spi_dout)
	);
	// ----------------
	// tasks
	// ----------------
	task automatic complete_run();
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic send(input int nb, input logic [31:0] tx);
		@(negedge sys_clk);
		host_u.xfer(nb, tx, mode3, rx);
	endtask
	always @(posedge spi_clk)
		if (spi_dout_oe === 1'b1)
			oe_hits++;
	task automatic st(input logic [7:0] exp);
		int n0;
		n0 = oe_hits;
		send(2, 32'h0000_0500);
		check(rx, exp, "status");
		check(8'(oe_hits - n0), 8'h08, "output enable count");
		check({7'h00, spi_dout_oe}, 8'h00, "output enable idle");
	endtask
	task automatic op_st(input int nb, input logic [31:0] tx, input logic [7:0] exp);
		send(nb, tx);
		st(exp);
	endtask
	// bounded poll of the busy bit
	task automatic settle(input logic [7:0] exp);
		for (int n = 0; n < 40; n++)
		begin
			send(2, 32'h0000_0500);
			if (rx[0] === 1'b0)
				break;
		end
		st(exp);
	endtask
	task automatic wr_sr(input logic [7:0] v, input logic [7:0] exp);
		send(1, 32'h0000_0006);
		send(2, {16'h0000, 8'h01, v});
		settle(exp);
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			complete_run();
		end
	end
	initial
	begin
		repeat (4) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		st(8'h00);
		op_st(1, 32'h0000_0006, 8'h02);
		op_st(1, 32'h0000_00a5, 8'h02);
		op_st(4, 32'h0300_0000, 8'h02);
		op_st(1, 32'h0000_0004, 8'h00);
		op_st(2, 32'h0000_0600, 8'h00);
		op_st(4, 32'h0212_3455, 8'h00);
		send(1, 32'h0000_0006);
		op_st(4, 32'h0212_3455, 8'h03);
		op_st(1, 32'h0000_0004, 8'h03);
		settle(8'h00);
		send(4, 32'h0352_3400);
		check(rx, 8'h55, "array byte");
		wr_sr(8'hff, 8'h8c);
		send(1, 32'h0000_0006);
		op_st(4, 32'h0200_0011, 8'h8e);
		@(negedge sys_clk);
		write_protect_n = 1'b0;
		op_st(2, 32'h0000_0100, 8'h8e);
		@(negedge sys_clk);
		write_protect_n = 1'b1;
		wr_sr(8'h04, 8'h04);
		send(1, 32'h0000_0006);
		op_st(4, 32'h02f0_0022, 8'h06);
		op_st(4, 32'h022f_ff22, 8'h07);
		settle(8'h04);
		send(4, 32'h032f_ff00);
		check(rx, 8'h22, "unprotected byte");
		wr_sr(8'h44, 8'h44);
		send(1, 32'h0000_0006);
		op_st(4, 32'h0200_0533, 8'h47);
		settle(8'h04);
		wr_sr(8'h14, 8'h14);
		wr_sr(8'h44, 8'h54);
		send(1, 32'h0000_0006);
		op_st(4, 32'h0200_0533, 8'h56);
		send(4, 32'h03ff_c500);
		check(rx, 8'h33, "id page byte");
		st(8'h16);
		mode3 = 1'b1;
		st(8'h16);
		op_st(1, 32'h0000_0004, 8'h14);
		complete_run();
	end
endmodule
